// File: bench/irpe_core_model.sv
// Processor core model: takes vectored requests from the block.
// Assumes the bench asks for each acknowledge through ack_go.
`timescale 1ns/100ps
module irpe_core_model
	import irpe_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Vector side
	input wire irpe_vec_t vec_out,
	input wire logic ack_go,
	output logic vec_ack
);
	// One pulse per shown vector; the gap stops a double acknowledge
	always @(posedge mclk)
		vec_ack <= !reset && ack_go && vec_out.valid && !vec_ack;
endmodule

// File: bench/testbench.sv
// Self-checking bench for the interrupt request and priority block.
// Assumes AXI4-Lite answers in a few cycles and pins settle in four edges.
`timescale 1ns/100ps
module testbench;
	import irpe_pkg::*;
	logic mclk, reset, awvalid, wvalid, arvalid, bready, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, pc;
	logic [1:0] bresp, rresp;
	logic ta_ev, tb_ev, cv_ev, cmp, ack_go, vec_ack, irq;
	logic [7:0] pa;
	logic [5:0] pd;
	irpe_vec_t vec;
	int fails, checks, cyc;

	irpe_ctrl dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer_a_event(ta_ev), .timer_b_event(tb_ev),
		.converter_event(cv_ev), .port_a_pins(pa), .port_d_pins(pd),
		.comparator_out(cmp), .port_c_pin_request(pc), .vec_out(vec),
		.vec_ack(vec_ack), .irq_out(irq));
	irpe_core_model core (.mclk(mclk), .reset(reset), .vec_out(vec),
		.ack_go(ack_go), .vec_ack(vec_ack));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Write; address and data are released as each is taken
	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [11:0] idx, input logic [7:0] e, input logic [1:0] er);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		chk("rdata", {24'h0, e}, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	// Waits for a vector, compares it, then has the core take it
	task automatic vchk(input irpe_vec_t e);
		int n;
		n = 0;
		while (vec.valid !== 1'b1 && n < 12)
		begin
			@(posedge mclk);
			n++;
		end
		chk("vector", {24'h0, e}, {24'h0, vec});
		ack_go <= 1'b1;
		@(posedge mclk);
		ack_go <= 1'b0;
		tick(2);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [11:0] idx [8] = '{IDX_TA_ENH, IDX_TA_ENL, IDX_PA_ENH, IDX_PA_ENL,
			IDX_PC_REQ, IDX_PC_ENH, IDX_PC_ENL, IDX_CTL};
		foreach (idx[i])
			rd(idx[i], 8'h00, RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
		$display("reset values done");
	endtask

	task automatic t_regs();
		wr(IDX_TA_ENL, 8'h61, RESP_OKAY);
		rd(IDX_TA_ENL, 8'h61, RESP_OKAY);
		wr(IDX_TA_ENH, 8'h61, RESP_OKAY);
		rd(IDX_TA_ENH, 8'h61, RESP_OKAY);
		wr(12'h010, 8'h5a, RESP_SLVERR);
		rd(12'h010, 8'h00, RESP_SLVERR);
		wr(IDX_TA_ENH, 8'h00, RESP_OKAY);
		wr(IDX_TA_ENL, 8'h00, RESP_OKAY);
		$display("register access done");
	endtask

	// Master enable clear: the core must poll
	task automatic t_poll();
		pc <= 4'h4;
		tick(8);
		rd(IDX_PC_REQ, 8'h04, RESP_OKAY);
		chk("no vector", 32'h0, {31'h0, vec.valid});
		wr(IDX_PC_REQ, 8'h00, RESP_OKAY);
		rd(IDX_PC_REQ, 8'h00, RESP_OKAY);
		pc <= 4'h0;
		$display("polled request done");
	endtask

	// Every code on the converter, then the second timer at level 2
	task automatic t_codes();
		wr(IDX_CTL, 8'h80, RESP_OKAY);
		for (int c = 1; c < 4; c++)
		begin
			wr(IDX_TA_ENH, {7'h0, c[1]}, RESP_OKAY);
			wr(IDX_TA_ENL, {7'h0, c[0]}, RESP_OKAY);
			cv_ev <= 1'b1;
			@(posedge mclk);
			cv_ev <= 1'b0;
			vchk('{1'b1, irpe_pri_t'(c), TA_BASE});
		end
		wr(IDX_TA_ENH, 8'h40, RESP_OKAY);
		wr(IDX_TA_ENL, 8'h00, RESP_OKAY);
		tb_ev <= 1'b1;
		@(posedge mclk);
		tb_ev <= 1'b0;
		vchk('{1'b1, PRI_NOM, TA_BASE + 5'h06});
		cv_ev <= 1'b1;
		@(posedge mclk);
		cv_ev <= 1'b0;
		tick(4);
		chk("disabled", 32'h0, {31'h0, vec.valid});
		rd(IDX_TA_REQ, 8'h01, RESP_OKAY);
		$display("priority codes done");
	endtask

	// Level 3 on port A beats level 1 on port C; port D then feeds bit 0
	task automatic t_prio();
		wr(IDX_PA_ENH, 8'h09, RESP_OKAY);
		wr(IDX_PA_ENL, 8'h09, RESP_OKAY);
		wr(IDX_PC_ENL, 8'h01, RESP_OKAY);
		pa <= 8'h08;
		pc <= 4'h1;
		tick(6);
		vchk('{1'b1, PRI_HIGH, PA_BASE + 5'h03});
		vchk('{1'b1, PRI_LOW, PC_BASE});
		wr(IDX_PSEL, 8'h01, RESP_OKAY);
		pd <= 6'h01;
		vchk('{1'b1, PRI_HIGH, PA_BASE});
		wr(IDX_EV_MASK, 8'h07, RESP_OKAY);
		tick(2);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(IDX_EV_STAT, 8'h07, RESP_OKAY);
		tick(2);
		chk("irq clear", 32'h0, {31'h0, irq});
		$display("priority order done");
	endtask

	// Comparator on bit 6, first timer, and a port C high code with irq unmasked
	task automatic t_shared();
		wr(IDX_PSEL, 8'h41, RESP_OKAY);
		wr(IDX_PA_ENH, 8'h49, RESP_OKAY);
		cmp <= 1'b1;
		vchk('{1'b1, PRI_NOM, PA_BASE + 5'h06});
		chk("irq event", 32'h1, {31'h0, irq});
		wr(IDX_TA_ENH, 8'h20, RESP_OKAY);
		ta_ev <= 1'b1;
		@(posedge mclk);
		ta_ev <= 1'b0;
		vchk('{1'b1, PRI_NOM, TA_BASE + 5'h05});
		wr(IDX_PC_ENH, 8'h08, RESP_OKAY);
		wr(IDX_PC_ENL, 8'h09, RESP_OKAY);
		pc <= 4'h9;
		vchk('{1'b1, PRI_HIGH, PC_BASE + 5'h03});
		$display("shared sources done");
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			complete_run();
		end
	end

	initial
	begin
		{reset, awvalid, wvalid, arvalid, ta_ev, tb_ev, cv_ev, cmp, ack_go} = 9'h100;
		{bready, rready, wstrb} = 6'h3f;
		{awaddr, araddr, wdata, pa, pd, pc} = '0;
		tick(8);
		reset <= 1'b0;
		tick(2);
		t_reset();
		t_regs();
		t_poll();
		t_codes();
		t_prio();
		t_shared();
		complete_run();
	end
endmodule

// File: verilog/irpe_arbiter.sv
// Fixed-order priority picker over all request sources.
// Assumes levels already decoded; purely combinational.
`timescale 1ns/100ps
module irpe_arbiter
	import irpe_pkg::*;
#(
	parameter int N = NSRC
)
(
	// Candidates
	input wire logic [N-1:0] pending,
	input wire logic [N-1:0][1:0] level,
	// Winner
	output logic best_valid,
	output logic [SRC_ID_W-1:0] best_id,
	output irpe_pri_t best_level
);

	// Strict compare: equal levels keep the lowest id
	always_comb
	begin
		best_valid = 1'b0;
		best_id = '0;
		best_level = PRI_OFF;
		for (int i = 0; i < N; i++)
		begin
			if (pending[i] && (level[i] > best_level))
			begin
				best_valid = 1'b1;
				best_id = SRC_ID_W'(i);
				best_level = irpe_pri_t'(level[i]);
			end
		end
	end

endmodule

// File: verilog/irpe_ctrl.sv
// Interrupt request flags, enable/priority pairs and vectored forwarding.
// Assumes an AXI4-Lite master on mclk and a core that pulses vec_ack once per taken vector.
//
// Behaviour
// - A port C pin request sets its bit in the port C request register.
// - With master enable set, the best pending enabled request goes to the core.
// - Port C request bits 3..0 match pins 3..0.
// - Same bit of timer high and low enables forms a two-bit code.
// - Code 00 off, 01 level 1, 10 level 2, 11 level 3.
// - Timer enables: bit 6 second timer, bit 5 first timer, bit 0 converter.
// - Port A requests use the same high/low enable coding.
// - Port A bit 7 pin 7, bit 6 pin 6 or comparator, 5..0 pins.
// - Port A bits 5..0 come from port A or port D per select register.
// - Port A low enable bits supply the low half of each code.
// - Port C requests have their own high/low enable pair.
// - A master enable bit gates all vectored interrupts.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module irpe_ctrl
	import irpe_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// On-chip event pulses
	input wire logic timer_a_event,
	input wire logic timer_b_event,
	input wire logic converter_event,
	// Pins
	input wire logic [7:0] port_a_pins,
	input wire logic [5:0] port_d_pins,
	input wire logic comparator_out,
	input wire logic [3:0] port_c_pin_request,
	// Core side
	output irpe_vec_t vec_out,
	input wire logic vec_ack,
	output logic irq_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ta_req_reg, ta_req_next, ta_enh_reg, ta_enh_next, ta_enl_reg, ta_enl_next;
	logic [7:0] pa_req_reg, pa_req_next, pa_enh_reg, pa_enh_next, pa_enl_reg, pa_enl_next;
	logic [7:0] pc_req_reg, pc_req_next, pc_enh_reg, pc_enh_next, pc_enl_reg, pc_enl_next;
	logic [7:0] ctl_reg, ctl_next, psel_reg, psel_next;
	logic [7:0] ev_stat_reg, ev_stat_next, ev_mask_reg, ev_mask_next;
	irpe_vec_t vec_reg, vec_next;
	logic irq_reg, irq_next;
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic wstrb0_reg, wstrb0_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [7:0] rbyte_reg, rbyte_next;

	// ----------------------------------------------------------------
	// Event capture
	// ----------------------------------------------------------------
	logic [18:0] pin_rise;
	logic [7:0] pa_rise;
	logic [5:0] pd_rise;
	logic cmp_rise;
	logic [3:0] pc_rise;
	logic [7:0] ta_set, pa_set, pc_set;
	logic [7:0] ev_set;

	// All pins share one synchroniser bank
	irpe_pin_sync #(.WIDTH(19)) u_sync
	(
		.mclk(mclk),
		.reset(reset),
		.pin_async({port_c_pin_request, comparator_out, port_d_pins, port_a_pins}),
		.rise(pin_rise)
	);

	assign pa_rise = pin_rise[7:0];
	assign pd_rise = pin_rise[13:8];
	assign cmp_rise = pin_rise[14];
	assign pc_rise = pin_rise[18:15];

	// Map edges and pulses onto request bit positions
	always_comb
	begin
		ta_set = '0;
		ta_set[TA_BIT_TIMER_B] = timer_b_event;
		ta_set[TA_BIT_TIMER_A] = timer_a_event;
		ta_set[TA_BIT_CONV] = converter_event;
		pa_set = '0;
		pa_set[PA_BIT_PIN7] = pa_rise[PA_BIT_PIN7];
		pa_set[PA_BIT_SHARED] = psel_reg[PSEL_BIT_CMP] ? cmp_rise : pa_rise[PA_BIT_SHARED];
		for (int i = 0; i < PA_LOW_PINS; i++)
		begin
			pa_set[i] = psel_reg[i] ? pd_rise[i] : pa_rise[i];
		end
		pc_set = {4'h0, pc_rise};
		ev_set = '0;
		ev_set[EV_BIT_PC] = |pc_set;
		ev_set[EV_BIT_TA] = |ta_set;
		ev_set[EV_BIT_PA] = |pa_set;
	end

	// ----------------------------------------------------------------
	// Register write decode and next values
	// ----------------------------------------------------------------
	logic wr_en, wr_ok;
	logic [11:0] wr_idx;
	logic [7:0] wb;
	logic [NSRC-1:0] ack_clr;

	function automatic logic idx_known(input logic [11:0] idx);
		idx_known = (idx >= IDX_TA_REQ && idx <= IDX_PC_ENL) || idx == IDX_CTL
			|| (idx >= IDX_PSEL && idx <= IDX_VEC);
	endfunction

	// Masked byte update helper
	function automatic logic [7:0] upd(input logic hit, input logic [7:0] old,
		input logic [7:0] val, input logic [7:0] wmask);
		upd = hit ? ((val & wmask) | (old & ~wmask)) : old;
	endfunction

	// Hardware set always beats a clearing write or acknowledge
	always_comb
	begin
		wr_en = aw_hold_reg && w_hold_reg && !bvalid_reg;
		wr_idx = awaddr_reg[ADDR_W-1:2];
		wr_ok = wr_en && wstrb0_reg;
		wb = wbyte_reg;
		ack_clr = '0;
		if (vec_ack && vec_reg.valid)
		begin
			ack_clr[vec_reg.id] = 1'b1;
		end
		ta_enh_next = upd(wr_ok && wr_idx == IDX_TA_ENH, ta_enh_reg, wb, 8'hff);
		ta_enl_next = upd(wr_ok && wr_idx == IDX_TA_ENL, ta_enl_reg, wb, TA_ENL_WMASK);
		pa_enh_next = upd(wr_ok && wr_idx == IDX_PA_ENH, pa_enh_reg, wb, 8'hff);
		pa_enl_next = upd(wr_ok && wr_idx == IDX_PA_ENL, pa_enl_reg, wb, 8'hff);
		pc_enh_next = upd(wr_ok && wr_idx == IDX_PC_ENH, pc_enh_reg, wb, 8'hff);
		pc_enl_next = upd(wr_ok && wr_idx == IDX_PC_ENL, pc_enl_reg, wb, 8'hff);
		ctl_next = upd(wr_ok && wr_idx == IDX_CTL, ctl_reg, wb, CTL_WMASK);
		psel_next = upd(wr_ok && wr_idx == IDX_PSEL, psel_reg, wb, PSEL_WMASK);
		ev_mask_next = upd(wr_ok && wr_idx == IDX_EV_MASK, ev_mask_reg, wb, EV_WMASK);
		ta_req_next = (upd(wr_ok && wr_idx == IDX_TA_REQ, ta_req_reg, wb, 8'hff)
			& ~ack_clr[TA_BASE +: GRP_W]) | ta_set;
		pa_req_next = (upd(wr_ok && wr_idx == IDX_PA_REQ, pa_req_reg, wb, 8'hff)
			& ~ack_clr[PA_BASE +: GRP_W]) | pa_set;
		pc_req_next = (upd(wr_ok && wr_idx == IDX_PC_REQ, pc_req_reg, wb, 8'hff)
			& ~ack_clr[PC_BASE +: GRP_W]) | pc_set;
		ev_stat_next = ev_stat_reg & ~((wr_ok && wr_idx == IDX_EV_STAT) ? wb : 8'h00);
		ev_stat_next = (ev_stat_next & EV_WMASK) | ev_set;
		irq_next = |(ev_stat_next & ev_mask_next);
	end

	// ----------------------------------------------------------------
	// Priority decode and vector selection
	// ----------------------------------------------------------------
	logic [NSRC-1:0] pend_next;
	logic [NSRC-1:0][1:0] lvl_next;
	logic best_valid;
	logic [SRC_ID_W-1:0] best_id;
	irpe_pri_t best_level;

	// Reserved positions never compete, whatever software left there
	assign pend_next = {pc_req_next & PC_SRC_MASK, pa_req_next & PA_SRC_MASK,
		ta_req_next & TA_SRC_MASK};

	// Per-bit high/low pair forms the level code
	for (genvar g = 0; g < GRP_W; g++)
	begin : g_code
		assign lvl_next[TA_BASE + g] = {ta_enh_next[g], ta_enl_next[g]};
		assign lvl_next[PA_BASE + g] = {pa_enh_next[g], pa_enl_next[g]};
		assign lvl_next[PC_BASE + g] = {pc_enh_next[g], pc_enl_next[g]};
	end

	irpe_arbiter #(.N(NSRC)) u_arb
	(
		.pending(pend_next),
		.level(lvl_next),
		.best_valid(best_valid),
		.best_id(best_id),
		.best_level(best_level)
	);

	// Built from next values so an acknowledged source drops on the same edge
	always_comb
	begin
		vec_next.valid = ctl_next[CTL_BIT_MASTER] && best_valid;
		vec_next.level = best_level;
		vec_next.id = best_id;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic [11:0] rd_idx;
	logic [7:0] rd_val;

	// Read mux; polling reads see raw request flags
	always_comb
	begin
		rd_idx = s_axi_araddr[ADDR_W-1:2];
		case (rd_idx)
			IDX_TA_REQ: rd_val = ta_req_reg;
			IDX_TA_ENH: rd_val = ta_enh_reg;
			IDX_TA_ENL: rd_val = ta_enl_reg;
			IDX_PA_REQ: rd_val = pa_req_reg;
			IDX_PA_ENH: rd_val = pa_enh_reg;
			IDX_PA_ENL: rd_val = pa_enl_reg;
			IDX_PC_REQ: rd_val = pc_req_reg;
			IDX_PC_ENH: rd_val = pc_enh_reg;
			IDX_PC_ENL: rd_val = pc_enl_reg;
			IDX_CTL: rd_val = ctl_reg;
			IDX_PSEL: rd_val = psel_reg;
			IDX_EV_STAT: rd_val = ev_stat_reg;
			IDX_EV_MASK: rd_val = ev_mask_reg;
			IDX_VEC: rd_val = vec_reg;
			default: rd_val = RST_BYTE;
		endcase
	end

	// Address and data taken in either order; one write completes at a time
	always_comb
	begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wbyte_next = wbyte_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && awready_reg)
		begin
			aw_hold_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg)
		begin
			w_hold_next = 1'b1;
			wbyte_next = s_axi_wdata[7:0];
			wstrb0_next = s_axi_wstrb[0];
		end
		if (wr_en)
		begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = idx_known(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_reg && s_axi_bready)
		begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_hold_next && !bvalid_next;
		wready_next = !w_hold_next && !bvalid_next;
		rvalid_next = rvalid_reg;
		rbyte_next = rbyte_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid && arready_reg)
		begin
			rvalid_next = 1'b1;
			rbyte_next = rd_val;
			rresp_next = idx_known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ta_req_reg <= RST_BYTE;
			ta_enh_reg <= RST_BYTE;
			ta_enl_reg <= RST_BYTE;
			pa_req_reg <= RST_BYTE;
			pa_enh_reg <= RST_BYTE;
			pa_enl_reg <= RST_BYTE;
			pc_req_reg <= RST_BYTE;
			pc_enh_reg <= RST_BYTE;
			pc_enl_reg <= RST_BYTE;
			ctl_reg <= RST_BYTE;
			psel_reg <= RST_BYTE;
			ev_stat_reg <= RST_BYTE;
			ev_mask_reg <= RST_BYTE;
			vec_reg <= '0;
			irq_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wbyte_reg <= RST_BYTE;
			wstrb0_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rbyte_reg <= RST_BYTE;
			rresp_reg <= RESP_OKAY;
		end
		else
		begin
			ta_req_reg <= ta_req_next;
			ta_enh_reg <= ta_enh_next;
			ta_enl_reg <= ta_enl_next;
			pa_req_reg <= pa_req_next;
			pa_enh_reg <= pa_enh_next;
			pa_enl_reg <= pa_enl_next;
			pc_req_reg <= pc_req_next;
			pc_enh_reg <= pc_enh_next;
			pc_enl_reg <= pc_enl_next;
			ctl_reg <= ctl_next;
			psel_reg <= psel_next;
			ev_stat_reg <= ev_stat_next;
			ev_mask_reg <= ev_mask_next;
			vec_reg <= vec_next;
			irq_reg <= irq_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wbyte_reg <= wbyte_next;
			wstrb0_reg <= wstrb0_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rbyte_reg <= rbyte_next;
			rresp_reg <= rresp_next;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = {24'h000000, rbyte_reg};
	assign vec_out = vec_reg;
	assign irq_out = irq_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [NSRC-1:0] pend_now;
	logic [1:0] max_lvl;

	// Highest enabled level among currently held requests
	always_comb
	begin
		pend_now = {pc_req_reg & PC_SRC_MASK, pa_req_reg, ta_req_reg & TA_SRC_MASK};
		max_lvl = 2'h0;
		for (int i = 0; i < GRP_W; i++)
		begin
			if (pend_now[TA_BASE + i] && {ta_enh_reg[i], ta_enl_reg[i]} > max_lvl)
				max_lvl = {ta_enh_reg[i], ta_enl_reg[i]};
			if (pend_now[PA_BASE + i] && {pa_enh_reg[i], pa_enl_reg[i]} > max_lvl)
				max_lvl = {pa_enh_reg[i], pa_enl_reg[i]};
			if (pend_now[PC_BASE + i] && {pc_enh_reg[i], pc_enl_reg[i]} > max_lvl)
				max_lvl = {pc_enh_reg[i], pc_enl_reg[i]};
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence both_halves_s;
		aw_hold_reg && w_hold_reg && !bvalid_reg;
	endsequence

	sequence idle_regs_s;
		!wr_en && !vec_ack;
	endsequence

	pc_pin_set_a: assert property ((pc_rise != 4'h0) |=>
		((pc_req_reg[3:0] & $past(pc_rise)) == $past(pc_rise)))
		else $error("port C edge did not set its request bit");
	vec_gate_a: assert property (vec_reg.valid |-> ctl_reg[CTL_BIT_MASTER])
		else $error("vector offered with master enable clear");
	vec_fwd_a: assert property ((ctl_reg[CTL_BIT_MASTER] && max_lvl != 2'h0)
		|-> vec_reg.valid) else $error("enabled pending request not forwarded");
	vec_pri_a: assert property (vec_reg.valid |->
		(vec_reg.level == max_lvl && vec_reg.level != PRI_OFF))
		else $error("vector not at highest pending level");
	timer_code_a: assert property ((vec_reg.valid && vec_reg.id == TA_BASE + 5'h06)
		|-> vec_reg.level == {ta_enh_reg[6], ta_enl_reg[6]})
		else $error("second timer level mismatches its pair");
	req_hold_a: assert property (idle_regs_s |=>
		((pend_now & $past(pend_now)) == $past(pend_now)))
		else $error("request dropped without write or ack");
	ack_clear_a: assert property ((vec_ack && vec_reg.valid && !wr_en
		&& !(ta_set != 8'h00 || pa_set != 8'h00 || pc_set != 8'h00))
		|=> !pend_now[$past(vec_reg.id)]) else $error("ack did not clear request");
	write_resp_a: assert property (both_halves_s |=> s_axi_bvalid ##0 !s_axi_awready)
		else $error("write response missing");
	irq_line_a: assert property ((ev_set != 8'h00 && ev_mask_next == EV_WMASK)
		|=> irq_out) else $error("unmasked event did not raise interrupt");

endmodule

// File: verilog/irpe_pin_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes pins are asynchronous to mclk; output pulse is combinational on mclk.
`timescale 1ns/100ps
module irpe_pin_sync
	import irpe_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Pins and edge pulses
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;
	logic [WIDTH-1:0] agree;

	// A change counts only once stages two and three agree
	always_comb
	begin
		agree = ~(s2_reg ^ s3_reg);
		level_next = (agree & s2_reg) | (~agree & level_reg);
		rise = level_next & ~level_reg;
	end

	// Stage one is read by stage two only
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end
		else
		begin
			s1_reg <= pin_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

endmodule

// File: verilog/irpe_pkg.sv
// Package for the interrupt request / priority enable block.
// Assumes a 32-bit AXI4-Lite register port; every register is 8 bits in the low byte.
package irpe_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam logic [11:0] IDX_TA_REQ = 12'hfc0;
	localparam logic [11:0] IDX_TA_ENH = 12'hfc1;
	localparam logic [11:0] IDX_TA_ENL = 12'hfc2;
	localparam logic [11:0] IDX_PA_REQ = 12'hfc3;
	localparam logic [11:0] IDX_PA_ENH = 12'hfc4;
	localparam logic [11:0] IDX_PA_ENL = 12'hfc5;
	localparam logic [11:0] IDX_PC_REQ = 12'hfc6;
	localparam logic [11:0] IDX_PC_ENH = 12'hfc7;
	localparam logic [11:0] IDX_PC_ENL = 12'hfc8;
	localparam logic [11:0] IDX_CTL = 12'hfcf;
	localparam logic [11:0] IDX_PSEL = 12'hfd0;
	localparam logic [11:0] IDX_EV_STAT = 12'hfd1;
	localparam logic [11:0] IDX_EV_MASK = 12'hfd2;
	localparam logic [11:0] IDX_VEC = 12'hfd3;

	// ----------------------------------------------------------------
	// Reset values, write masks and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] TA_SRC_MASK = 8'h61;
	localparam logic [7:0] TA_ENL_WMASK = 8'h79;
	localparam logic [7:0] PA_SRC_MASK = 8'hff;
	localparam logic [7:0] PC_SRC_MASK = 8'h0f;
	localparam logic [7:0] CTL_WMASK = 8'h80;
	localparam logic [7:0] PSEL_WMASK = 8'h7f;
	localparam logic [7:0] EV_WMASK = 8'h07;
	localparam int TA_BIT_TIMER_B = 6;
	localparam int TA_BIT_TIMER_A = 5;
	localparam int TA_BIT_CONV = 0;
	localparam int PA_BIT_PIN7 = 7;
	localparam int PA_BIT_SHARED = 6;
	localparam int PA_LOW_PINS = 6;
	localparam int CTL_BIT_MASTER = 7;
	localparam int PSEL_BIT_CMP = 6;
	localparam int EV_BIT_PC = 0;
	localparam int EV_BIT_TA = 1;
	localparam int EV_BIT_PA = 2;

	// ----------------------------------------------------------------
	// Sources: timer/converter ids 0-7, port A 8-15, port C 16-23
	// ----------------------------------------------------------------
	localparam int GRP_W = 8;
	localparam int NSRC = 24;
	localparam int SRC_ID_W = 5;
	localparam logic [SRC_ID_W-1:0] TA_BASE = 5'h00;
	localparam logic [SRC_ID_W-1:0] PA_BASE = 5'h08;
	localparam logic [SRC_ID_W-1:0] PC_BASE = 5'h10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Enable / priority code, high bit then low bit
	typedef enum logic [1:0]
	{
		PRI_OFF = 2'h0,
		PRI_LOW = 2'h1,
		PRI_NOM = 2'h2,
		PRI_HIGH = 2'h3
	} irpe_pri_t;

	// Vectored request to the core
	typedef struct packed
	{
		logic valid;
		irpe_pri_t level;
		logic [SRC_ID_W-1:0] id;
	} irpe_vec_t;

endpackage
